//--- field_ops_exec.sv
// field_ops_exec.sv: execute-stage slice for bit field clear and
// equality compare, result registered at end of the execute cycle.
// assumes decoder drives operands, predicate and a one-cycle issue.
`timescale 1ns/10ps
`default_nettype none
module field_ops_exec
   import field_ops_pkg::*;
(
   // clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_reset,
   // issue
   input  wire logic              i_issue,
   input  wire op_sel_t           i_op,
   input  wire logic              i_predicate,
   input  wire logic [4:0]        i_dst_index,
   // clear operands
   input  wire logic              i_clear_reg_form,
   input  wire logic [CST5_W-1:0] i_low_cst,
   input  wire logic [CST5_W-1:0] i_high_cst,
   // compare operands
   input  wire first_source_form_t        i_first_source_form,
   input  wire logic [CST5_W-1:0] i_first_source_cst,
   input  wire logic              i_second_source_long,
   // source data
   input  wire logic [WORD_W-1:0] i_first_source,
   input  wire logic [LONG_W-1:0] i_second_source,
   // write-back
   output logic                   o_wr_en,
   output logic      [4:0]        o_wr_index,
   output logic      [WORD_W-1:0] o_wr_data
);

   // decoded issue
   logic              issue_taken;
   logic              issue_writes;

   // field bounds
   logic [POS_W-1:0]  reg_low_pos;
   logic [POS_W-1:0]  reg_high_pos;
   logic [POS_W-1:0]  low_pos;
   logic [POS_W-1:0]  high_pos;

   // clear datapath
   logic [WORD_W-1:0] second_word;
   logic [WORD_W-1:0] field_mask;
   logic [WORD_W-1:0] keep_mask;
   logic [WORD_W-1:0] clear_result;

   // compare datapath
   logic [LONG_W-1:0] first_source_cst_ext;
   logic [LONG_W-1:0] first_source_reg_ext;
   logic [LONG_W-1:0] second_source_word_ext;
   logic [LONG_W-1:0] cmp_a;
   logic [LONG_W-1:0] cmp_b;
   logic              cmp_low_equal;
   logic              cmp_high_equal;
   logic              cmp_equal;
   logic [WORD_W-1:0] cmp_result;

   // write-back state
   logic              wr_en_reg;
   logic              wr_en_next;
   logic [4:0]        wr_index_reg;
   logic [4:0]        wr_index_next;
   logic [WORD_W-1:0] wr_data_reg;
   logic [WORD_W-1:0] wr_data_next;

   // instruction in execute with a true predicate
   assign issue_taken  = i_issue && i_predicate;
   // op none writes nothing to the register file
   assign issue_writes = issue_taken && (i_op != OP_NONE);

   // register form: bounds in the ten low bits of first source
   assign reg_high_pos = i_first_source[HIGH_POS_LSB +: POS_W];
   assign reg_low_pos  = i_first_source[LOW_POS_LSB +: POS_W];

   // bound selection; upper 22 bits of first source ignored
   always_comb
   begin
      if (i_clear_reg_form)
      begin
         high_pos = reg_high_pos;
         low_pos  = reg_low_pos;
      end
      else
      begin
         low_pos  = i_low_cst;
         high_pos = i_high_cst;
      end
   end

   field_clear_mask #(
      .W (WORD_W)
   ) u_mask (
      .i_low_pos  (low_pos),
      .i_high_pos (high_pos),
      .o_mask     (field_mask)
   );

   // clear works on the low word of second source
   assign second_word  = i_second_source[WORD_W-1:0];
   assign keep_mask    = ~field_mask;
   // other bits pass unchanged
   assign clear_result = second_word & keep_mask;

   // signed operands widened to the compare width
   assign first_source_cst_ext  = {{(LONG_W-CST5_W){i_first_source_cst[CST5_W-1]}},
                           i_first_source_cst};
   assign first_source_reg_ext  = {{(LONG_W-WORD_W){i_first_source[WORD_MSB]}},
                           i_first_source};
   assign second_source_word_ext = {{(LONG_W-WORD_W){second_word[WORD_MSB]}},
                           second_word};

   // first source: register or constant
   always_comb
   begin
      if (i_first_source_form == FIRST_SOURCE_CST5)
      begin
         cmp_a = first_source_cst_ext;
      end
      else
      begin
         cmp_a = first_source_reg_ext;
      end
   end

   // second source: word or 40-bit pair
   always_comb
   begin
      if (i_second_source_long)
      begin
         cmp_b = i_second_source;
      end
      else
      begin
         cmp_b = second_source_word_ext;
      end
   end

   // equality split into low word and extension byte
   assign cmp_low_equal  = (cmp_a[WORD_W-1:0] == cmp_b[WORD_W-1:0]);
   assign cmp_high_equal = (cmp_a[LONG_W-1:WORD_W] == cmp_b[LONG_W-1:WORD_W]);
   assign cmp_equal      = cmp_low_equal && cmp_high_equal;
   assign cmp_result     = cmp_equal ? CMP_TRUE : CMP_FALSE;

   // result select
   always_comb
   begin
      case (i_op)
         OP_CLEAR:
         begin
            wr_data_next = clear_result;
         end
         OP_EQ_CMP:
         begin
            wr_data_next = cmp_result;
         end
         default:
         begin
            wr_data_next = WORD_RESET;
         end
      endcase
   end

   // next strobe and destination
   assign wr_en_next    = issue_writes;
   assign wr_index_next = i_dst_index;

   // write strobe: one cycle after a writing issue
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         wr_en_reg <= 1'b0;
      end
      else
      begin
         wr_en_reg <= wr_en_next;
      end
   end

   // destination index, held until the next taken issue
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         wr_index_reg <= 5'h00;
      end
      else if (issue_taken)
      begin
         wr_index_reg <= wr_index_next;
      end
   end

   // result, captured in the execute cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         wr_data_reg <= WORD_RESET;
      end
      else if (issue_taken)
      begin
         wr_data_reg <= wr_data_next;
      end
   end

   assign o_wr_en    = wr_en_reg;
   assign o_wr_index = wr_index_reg;
   assign o_wr_data  = wr_data_reg;

endmodule
`default_nettype wire

//--- field_ops_pkg.sv
// field_ops_pkg.sv: constants and operand-form encodings for the
// bit field clear and equality compare execute slice.
// assumes the decoder presents operands already selected from the
// register file, with the predicate already evaluated.
package field_ops_pkg;

   localparam int WORD_W        = 32;
   localparam int LONG_W        = 40;
   localparam int POS_W         = 5;
   localparam int CST5_W        = 5;
   localparam int HIGH_POS_LSB  = 0;
   localparam int LOW_POS_LSB   = 5;
   localparam int WORD_MSB      = 31;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [31:0] CMP_TRUE   = 32'h0000_0001;
   localparam logic [31:0] CMP_FALSE  = 32'h0000_0000;

   // operation select
   typedef enum logic [1:0]
   {
      OP_NONE     = 2'h0,
      OP_CLEAR    = 2'h1,
      OP_EQ_CMP   = 2'h2
   } op_sel_t;

   // first-source form of equality compare
   typedef enum logic
   {
      FIRST_SOURCE_REG    = 1'h0,
      FIRST_SOURCE_CST5   = 1'h1
   } first_source_form_t;

endpackage

//--- field_clear_mask.sv
// field_clear_mask.sv: builds the mask of an inclusive bit field.
// assumes bounds are 5-bit indices; low above high gives an empty mask.
`timescale 1ns/10ps
`default_nettype none
module field_clear_mask
   import field_ops_pkg::*;
#(
   parameter int W = 32
)
(
   // field bounds
   input  wire logic [POS_W-1:0] i_low_pos,
   input  wire logic [POS_W-1:0] i_high_pos,
   // mask of field bits
   output logic      [W-1:0]     o_mask
);

   always_comb
   begin
      o_mask = '0;
      for (int b = 0; b < W; b++)
      begin
         // bit 0 is lsb, bit W-1 is msb
         if ((b >= int'(i_low_pos)) && (b <= int'(i_high_pos)))
         begin
            o_mask[b] = 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

//--- field_ops_rf_model.sv
// register file side: counts write-back strobes
// assumes same clock and reset as the slice
`timescale 1ns/10ps
`default_nettype none
module field_ops_rf_model
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_wr_en,
   output logic      [15:0] o_count
);
   always_ff @(posedge i_ref_clk)
      if (i_reset)
         o_count <= 16'h0000;
      else if (i_wr_en)
         o_count <= o_count + 16'h0001;
endmodule
`default_nettype wire

//--- field_ops_exec_asserts.sv
// checker on the slice ports
// assumes bound onto field_ops_exec below
`timescale 1ns/10ps
`default_nettype none
module field_ops_chk
   import field_ops_pkg::*;
(
   input wire logic i_ref_clk, i_reset, i_issue, i_predicate, o_wr_en,
   input wire logic i_clear_reg_form, i_second_source_long,
   input wire op_sel_t i_op,
   input wire first_source_form_t i_first_source_form,
   input wire logic [4:0] i_dst_index, o_wr_index, i_low_cst, i_high_cst,
   input wire logic [4:0] i_first_source_cst,
   input wire logic [31:0] i_first_source, o_wr_data,
   input wire logic [39:0] i_second_source
);
   wire logic go = i_issue && i_predicate && i_op != OP_NONE;
   wire logic [31:0] a = i_first_source;
   wire logic [31:0] b = i_second_source[31:0];
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   sequence s_eq;
      go && i_op == OP_EQ_CMP && i_first_source_form == FIRST_SOURCE_REG;
   endsequence
   sequence s_eq_cst;
      go && i_op == OP_EQ_CMP && i_first_source_form == FIRST_SOURCE_CST5 && !i_second_source_long;
   endsequence
   a_wr_strobe: assert property (go |=> o_wr_en) else $error("bad");
   a_no_wr: assert property (!go |=> !o_wr_en) else $error("bad");
   a_hold_data: assert property (!i_predicate |=> $stable(o_wr_data))
      else $error("bad");
   a_wr_index: assert property (go |=> o_wr_index == $past(i_dst_index))
      else $error("bad");
   a_clr_bit: assert property (go && i_op == OP_CLEAR &&
      !i_clear_reg_form && i_low_cst == i_high_cst |=>
      o_wr_data == $past(b & ~(32'h0000_0001 << i_low_cst))) else $error("bad");
   a_eq_word: assert property ((s_eq and !i_second_source_long) |=>
      o_wr_data == $past(a == b ? CMP_TRUE : CMP_FALSE)) else $error("bad");
   a_eq_bool: assert property (go && i_op == OP_EQ_CMP |=>
      o_wr_data[31:1] == 31'h0000_0000) else $error("bad");
   a_eq_long: assert property ((s_eq and i_second_source_long) |=> o_wr_data ==
      $past({{8{a[31]}}, a} == i_second_source ? CMP_TRUE : CMP_FALSE))
      else $error("bad");
   a_eq_cst: assert property (s_eq_cst |=> o_wr_data ==
      $past({{27{i_first_source_cst[4]}}, i_first_source_cst} == b ? CMP_TRUE : CMP_FALSE))
      else $error("bad");
endmodule
bind field_ops_exec field_ops_chk chk_u (.*);
`default_nettype wire

//--- field_ops_exec_tb.sv
// bench: corner and random issues into the slice
// assumes the checker is bound and the partner counts writes
`timescale 1ns/10ps
`default_nettype none
module field_ops_exec_tb;
   import field_ops_pkg::*;
   logic i_ref_clk = 1'b0, i_reset = 1'b1, o_wr_en;
   logic i_issue, i_predicate, i_clear_reg_form, i_second_source_long;
   op_sel_t i_op;
   first_source_form_t i_first_source_form;
   logic [4:0] i_dst_index, i_low_cst, i_high_cst, i_first_source_cst, o_wr_index;
   logic [31:0] i_first_source, o_wr_data, r, x;
   logic [39:0] i_second_source;
   logic [31:0] exp_data;
   logic [4:0] exp_index;
   logic exp_en;
   logic [15:0] wc, ec = 16'h0000;
   int n_mismatch = 0, n_tests = 0, seed = 94568, cyc = 0;
   field_ops_exec dut_u (.*);
   field_ops_rf_model rf_u (.i_ref_clk, .i_reset, .i_wr_en(o_wr_en),
      .o_count(wc));
   initial forever #12.5 i_ref_clk = ~i_ref_clk;
   task automatic check(input logic [39:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   // reference result of the issue now on the inputs
   function automatic logic [31:0] exp_result();
      logic [4:0]  lo;
      logic [4:0]  hi;
      logic [31:0] v;
      logic [39:0] p;
      logic [39:0] q;
      lo = i_clear_reg_form ? i_first_source[9:5] : i_low_cst;
      hi = i_clear_reg_form ? i_first_source[4:0] : i_high_cst;
      v = i_second_source[31:0];
      for (int k = 0; k < 32; k++)
         if (k >= int'(lo) && k <= int'(hi))
            v[k] = 1'b0;
      p = (i_first_source_form == FIRST_SOURCE_CST5) ? {{35{i_first_source_cst[4]}}, i_first_source_cst}
         : {{8{i_first_source[31]}}, i_first_source};
      q = i_second_source_long ? i_second_source
         : {{8{i_second_source[31]}}, i_second_source[31:0]};
      case (i_op)
         OP_CLEAR: exp_result = v;
         OP_EQ_CMP: exp_result = (p == q) ? 32'h0000_0001 : 32'h0000_0000;
         default: exp_result = 32'h0000_0000;
      endcase
   endfunction
   task automatic close_out();
      $display("%0d tests, %0d mismatches", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // control word: issue, predicate, form bits, bounds, index, op
   task automatic put(input logic [31:0] c, a, input logic [39:0] b);
      {i_dst_index, i_high_cst, i_low_cst, i_first_source_cst, i_second_source_long,
         i_clear_reg_form, i_predicate, i_issue} <= c[23:0];
      i_op <= op_sel_t'(c[25:24] % 2'h3);
      i_first_source_form <= first_source_form_t'(c[26]);
      i_first_source <= a;
      i_second_source <= b;
   endtask
   always @(posedge i_ref_clk)
   begin
      cyc <= cyc + 1;
      if (!i_reset && i_issue && i_predicate && i_op != OP_NONE)
         ec <= ec + 16'h0001;
      exp_en <= !i_reset && i_issue && i_predicate && i_op != OP_NONE;
      if (i_reset)
      begin
         exp_index <= 5'h00;
         exp_data <= 32'h0000_0000;
      end
      else if (i_issue && i_predicate)
      begin
         exp_index <= i_dst_index;
         exp_data <= exp_result();
      end
      if (cyc > 3000)
      begin
         n_mismatch++;
         close_out();
      end
   end
   always @(negedge i_ref_clk)
   begin
      check(40'(o_wr_en), 40'(exp_en));
      check(40'(o_wr_index), 40'(exp_index));
      check(40'(o_wr_data), 40'(exp_data));
   end
   initial
   begin
      put(32'h0100_0006, 32'h0000_0052, 40'h00_03B6_E7D5);
      repeat (20) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      i_issue <= 1'b1;
      @(posedge i_ref_clk);
      put(32'h0200_000B, 32'hF23A_3789, 40'hFF_F23A_3789);
      @(negedge i_ref_clk);
      check(40'(o_wr_data), 40'h00_03B0_0001);
      @(negedge i_ref_clk);
      check(40'(o_wr_data), 40'(CMP_TRUE));
      @(posedge i_ref_clk);
      put(32'h010C_C803, 32'h0000_0000, 40'h00_07A4_3F2A);
      @(posedge i_ref_clk);
      put(32'h0600_00C3, 32'h0000_0000, 40'h00_0000_000C);
      @(negedge i_ref_clk);
      check(40'(o_wr_data), 40'h00_07A0_000A);
      @(negedge i_ref_clk);
      check(40'(o_wr_data), 40'(CMP_TRUE));
      repeat (2500)
      begin
         @(posedge i_ref_clk);
         r = $random(seed);
         x = r[2] ? $random(seed) & 32'h0000_03FF : $random(seed);
         put(r, x, r[31] ? {{8{x[31]}}, x} : {x[7:0], r});
      end
      @(posedge i_ref_clk);
      i_issue <= 1'b0;
      repeat (2) @(negedge i_ref_clk);
      check(40'(wc), 40'(ec));
      close_out();
   end
endmodule
`default_nettype wire
